/* File: scsp_serial_control_slave_port.sv */
// Serial control slave port with address strap and reset registers
// What this block does
// - Strap picks one of eight addresses
// - SDA falling while SCL high starts
// - SDA rising while SCL high stops
// - Matching address gets ACK low
// - Mismatch: release SDA, ignore transaction
// - Each written data byte is ACKed
// - Lines only pulled low, never high
// - Register address overrides strap when set
// - Sleep bit powers down without link
// - Bit one resets everything, self clears
// - Bit zero resets logic, keeps registers
`timescale 1ns/1ps
`default_nettype none
`include "scsp_params.svh"
module scsp_serial_control_slave_port
(
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_NRST,
	// Bus lines, open drain
	input wire logic I_SCL_IN,
	output logic O_SCL_OUT,
	output logic O_SCL_OE,
	input wire logic I_SDA_IN,
	output logic O_SDA_OUT,
	output logic O_SDA_OE,
	// Digitised strap ratio and link status
	input wire logic [2:0] I_ADDRESS_SELECT_STRAP,
	input wire logic I_LINK_DETECTED,
	// Power and reset controls
	output logic O_POWER_DOWN,
	output logic O_LOGIC_RESET
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [5:0] meta_reg;
	logic [5:0] sync_reg;
	logic scl_d_reg;
	logic sda_d_reg;
	wire logic scl_s = sync_reg[0];
	wire logic sda_s = sync_reg[1];
	wire logic link_s = sync_reg[2];
	wire logic [2:0] strap_s = sync_reg[5:3];

	// Two stages, pins are asynchronous
	always_ff @(posedge I_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			meta_reg <= 6'h03;
			sync_reg <= 6'h03;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= {I_ADDRESS_SELECT_STRAP, I_LINK_DETECTED,
				I_SDA_IN, I_SCL_IN};
			sync_reg <= meta_reg;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Bus events
	// start detect
	wire logic start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire logic stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	wire logic scl_rise = scl_s & ~scl_d_reg;
	wire logic scl_fall = ~scl_s & scl_d_reg;

	// ----------------------------------------
	// Strap capture and address select
	// ----------------------------------------
	logic [1:0] wait_reg;
	logic [6:0] strap_addr_reg;
	logic [7:0] addr_cfg_reg;
	logic sleep_reg;

	// Caught once the synchroniser has settled
	always_ff @(posedge I_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			wait_reg <= 2'h0;
			strap_addr_reg <= `SCSP_STRAP_BASE;
		end
		else if (wait_reg != 2'h3)
		begin
			wait_reg <= wait_reg + 2'h1;
			if (wait_reg == `SCSP_STRAP_WAIT)
				strap_addr_reg <= `SCSP_STRAP_BASE + {3'h0, strap_s, 1'b0};
		end
	end

	wire logic [6:0] own_addr = addr_cfg_reg[`SCSP_OVR_BIT] ?
		addr_cfg_reg[7:1] : strap_addr_reg;

	// ----------------------------------------
	// Protocol engine
	// ----------------------------------------
	scsp_pkg::scsp_state_t st_reg, st_next;
	scsp_pkg::scsp_phase_t ph_reg, ph_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] ptr_reg, ptr_next;
	logic rw_reg, rw_next;
	logic oe_reg, oe_next;
	logic mack_reg, mack_next;
	logic wr_en;

	wire logic [7:0] rst_rd = {sleep_reg, 7'h00};
	wire logic [7:0] rd_byte = (ptr_reg == `SCSP_REG_ADDR_CFG) ?
		addr_cfg_reg : (ptr_reg == `SCSP_REG_RST_CTL) ? rst_rd : 8'h00;
	wire logic byte_done = scl_fall & (cnt_reg == 4'h8);
	wire logic addr_hit = sh_reg[7:1] == own_addr;

	// Next state; stop and start override any byte in flight
	always_comb
	begin
		st_next = st_reg;
		ph_next = ph_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		ptr_next = ptr_reg;
		rw_next = rw_reg;
		oe_next = oe_reg;
		mack_next = mack_reg;
		wr_en = 1'b0;
		if (stop_det)
		begin
			st_next = scsp_pkg::ST_IDLE;
			oe_next = 1'b0;
		end
		else if (start_det)
		begin
			st_next = scsp_pkg::ST_RECV;
			ph_next = scsp_pkg::PH_ADDR;
			cnt_next = 4'h0;
			oe_next = 1'b0;
		end
		else
			unique case (st_reg)
				scsp_pkg::ST_IDLE:
					st_next = scsp_pkg::ST_IDLE;
				scsp_pkg::ST_RECV:
					if (scl_rise)
					begin
						sh_next = {sh_reg[6:0], sda_s};
						cnt_next = cnt_reg + 4'h1;
					end
					else if (byte_done)
					begin
						cnt_next = 4'h0;
						st_next = scsp_pkg::ST_ACK;
						oe_next = 1'b1;
						if (ph_reg == scsp_pkg::PH_ADDR)
						begin
							rw_next = sh_reg[0];
							if (!addr_hit)
							begin
								st_next = scsp_pkg::ST_IDLE;
								oe_next = 1'b0;
							end
						end
						else if (ph_reg == scsp_pkg::PH_PTR)
							ptr_next = sh_reg;
						else
						begin
							wr_en = 1'b1;
							ptr_next = ptr_reg + 8'h01;
						end
					end
				scsp_pkg::ST_ACK:
					if (scl_fall)
					begin
						ph_next = (ph_reg == scsp_pkg::PH_ADDR && !rw_reg) ?
							scsp_pkg::PH_PTR : scsp_pkg::PH_DATA;
						st_next = scsp_pkg::ST_RECV;
						oe_next = 1'b0;
						if (ph_reg == scsp_pkg::PH_ADDR && rw_reg)
						begin
							st_next = scsp_pkg::ST_SEND;
							sh_next = rd_byte;
							ptr_next = ptr_reg + 8'h01;
							oe_next = ~rd_byte[7];
						end
					end
				scsp_pkg::ST_SEND:
					if (scl_fall)
					begin
						cnt_next = cnt_reg + 4'h1;
						sh_next = {sh_reg[6:0], 1'b0};
						oe_next = ~sh_reg[6];
						if (cnt_reg == 4'h7)
						begin
							st_next = scsp_pkg::ST_MACK;
							cnt_next = 4'h0;
							oe_next = 1'b0;
						end
					end
				scsp_pkg::ST_MACK:
					if (scl_rise)
						mack_next = ~sda_s;
					else if (scl_fall)
					begin
						st_next = scsp_pkg::ST_IDLE;
						if (mack_reg)
						begin
							st_next = scsp_pkg::ST_SEND;
							sh_next = rd_byte;
							ptr_next = ptr_reg + 8'h01;
							oe_next = ~rd_byte[7];
						end
					end
				default:
					st_next = scsp_pkg::ST_IDLE;
			endcase
	end

	// Engine registers
	always_ff @(posedge I_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			st_reg <= scsp_pkg::ST_IDLE;
			ph_reg <= scsp_pkg::PH_ADDR;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			oe_reg <= 1'b0;
			mack_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			ph_reg <= ph_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			ptr_reg <= ptr_next;
			rw_reg <= rw_next;
			oe_reg <= oe_next;
			mack_reg <= mack_next;
		end
	end

	// ----------------------------------------
	// Registers and outputs
	// ----------------------------------------
	wire logic wr_rst = wr_en & (ptr_reg == `SCSP_REG_RST_CTL);
	wire logic full_req = wr_rst & sh_reg[`SCSP_FULL_RST_BIT];
	wire logic keep_req = wr_rst & sh_reg[`SCSP_KEEP_RST_BIT];
	logic full_rst_reg;

	// Reset bits are pulses, so they read back as zero
	always_ff @(posedge I_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			addr_cfg_reg <= `SCSP_ADDR_CFG_RST;
			sleep_reg <= `SCSP_SLEEP_RST;
			full_rst_reg <= 1'b0;
		end
		else
		begin
			full_rst_reg <= full_req;
			if (full_rst_reg)
			begin
				addr_cfg_reg <= `SCSP_ADDR_CFG_RST;
				sleep_reg <= `SCSP_SLEEP_RST;
			end
			else if (wr_en && ptr_reg == `SCSP_REG_ADDR_CFG)
				addr_cfg_reg <= sh_reg;
			else if (wr_rst)
				sleep_reg <= sh_reg[`SCSP_SLEEP_BIT];
		end
	end

	// Output flops; clock line is never driven by this slave
	always_ff @(posedge I_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			O_SCL_OUT <= 1'b0;
			O_SCL_OE <= 1'b0;
			O_SDA_OUT <= 1'b0;
			O_SDA_OE <= 1'b0;
			O_POWER_DOWN <= 1'b0;
			O_LOGIC_RESET <= 1'b0;
		end
		else
		begin
			O_SCL_OUT <= 1'b0;
			O_SCL_OE <= 1'b0;
			O_SDA_OUT <= 1'b0;
			O_SDA_OE <= oe_next;
			O_POWER_DOWN <= sleep_reg & ~link_s;
			O_LOGIC_RESET <= keep_req | full_req;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);

	property p_strap;
		wait_reg == `SCSP_STRAP_WAIT |=>
			strap_addr_reg == `SCSP_STRAP_BASE + {3'h0, $past(strap_s), 1'b0};
	endproperty
	a_strap: assert property (p_strap) else $error("strap address");
	property p_start;
		start_det && !stop_det |=> st_reg == scsp_pkg::ST_RECV && cnt_reg == 4'h0;
	endproperty
	a_start: assert property (p_start) else $error("start missed");
	property p_stop;
		stop_det |=> st_reg == scsp_pkg::ST_IDLE && !O_SDA_OE;
	endproperty
	a_stop: assert property (p_stop) else $error("stop missed");
	property p_ack;
		st_reg == scsp_pkg::ST_RECV && byte_done && !start_det && !stop_det &&
			(ph_reg != scsp_pkg::PH_ADDR || addr_hit) |=> O_SDA_OE;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_nack;
		st_reg == scsp_pkg::ST_RECV && byte_done && !start_det && !stop_det &&
			ph_reg == scsp_pkg::PH_ADDR && !addr_hit |=>
			!O_SDA_OE && st_reg == scsp_pkg::ST_IDLE;
	endproperty
	a_nack: assert property (p_nack) else $error("bad ack");
	property p_wack;
		wr_en && !start_det |=> st_reg == scsp_pkg::ST_ACK && O_SDA_OE;
	endproperty
	a_wack: assert property (p_wack) else $error("write not acked");
	property p_od;
		!O_SDA_OUT && !O_SCL_OE;
	endproperty
	a_od: assert property (p_od) else $error("line driven high");
	// Override set: only the programmed address may be acknowledged
	property p_ovr;
		st_reg == scsp_pkg::ST_RECV && byte_done && !start_det &&
			!stop_det && ph_reg == scsp_pkg::PH_ADDR &&
			addr_cfg_reg[`SCSP_OVR_BIT] |=>
			O_SDA_OE == (sh_reg[7:1] == addr_cfg_reg[7:1]);
	endproperty
	a_ovr: assert property (p_ovr) else $error("address select");
	property p_sleep;
		1'b1 |=> O_POWER_DOWN == ($past(sleep_reg) & ~$past(link_s));
	endproperty
	a_sleep: assert property (p_sleep) else $error("power down");
	property p_full;
		full_req |=> O_LOGIC_RESET ##1 !O_LOGIC_RESET && !sleep_reg &&
			addr_cfg_reg == `SCSP_ADDR_CFG_RST;
	endproperty
	a_full: assert property (p_full) else $error("full reset");
	property p_keep;
		keep_req && !full_req |=> O_LOGIC_RESET &&
			addr_cfg_reg == $past(addr_cfg_reg) ##1 !O_LOGIC_RESET;
	endproperty
	a_keep: assert property (p_keep) else $error("keep reset");
	// Byte loaded for a read of the reset register has reserved bits clear
	property p_resv;
		((st_reg == scsp_pkg::ST_ACK && ph_reg == scsp_pkg::PH_ADDR &&
			rw_reg) || (st_reg == scsp_pkg::ST_MACK && mack_reg)) &&
			scl_fall && !start_det && !stop_det &&
			ptr_reg == `SCSP_REG_RST_CTL |=>
			st_reg == scsp_pkg::ST_SEND && sh_reg[6:0] == 7'h00;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits");

	c_addr: cover property (st_reg == scsp_pkg::ST_ACK && ph_reg == scsp_pkg::PH_ADDR);
	c_write: cover property (wr_en);
	c_read: cover property (st_reg == scsp_pkg::ST_MACK && scl_fall && mack_reg);
	c_nack: cover property (byte_done && ph_reg == scsp_pkg::PH_ADDR && !addr_hit);
endmodule : scsp_serial_control_slave_port
`default_nettype wire

/* File: scsp_params.svh */
// Offsets, field positions and reset values of the serial control port
`ifndef SCSP_PARAMS_SVH
`define SCSP_PARAMS_SVH
`define SCSP_REG_ADDR_CFG 8'h00
`define SCSP_REG_RST_CTL 8'h01
`define SCSP_ADDR_CFG_RST 8'h00
`define SCSP_SLEEP_RST 1'b0
`define SCSP_STRAP_BASE 7'h0C
`define SCSP_OVR_BIT 0
`define SCSP_SLEEP_BIT 7
`define SCSP_FULL_RST_BIT 1
`define SCSP_KEEP_RST_BIT 0
`define SCSP_STRAP_WAIT 2'h2
`endif

/* File: scsp_pkg.sv */
// Types of the serial control port
package scsp_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RECV = 5'h02,
		ST_ACK = 5'h04,
		ST_SEND = 5'h08,
		ST_MACK = 5'h10
	} scsp_state_t;
	typedef enum logic [1:0] {
		PH_ADDR = 2'h0,
		PH_PTR = 2'h1,
		PH_DATA = 2'h2
	} scsp_phase_t;
endpackage : scsp_pkg

/* File: scsp_host_model.sv */
// Behavioural bus master driving the serial control port
`timescale 1ns/1ps
`default_nettype none
module scsp_host_model
(
	// Clock
	input wire logic i_clk,
	// Wire level of the data line
	input wire logic i_sda,
	// Released-or-low drives, combined with the slave outside
	output logic o_scl,
	output logic o_sda,
	// One pulse per finished byte
	output logic o_res_valid,
	output logic o_res_ack,
	output logic [7:0] o_res_val
);
	// ------------------------------------------------------------
	// Bit timing: clock high for eight system clocks, low for at least nine
	// ------------------------------------------------------------
	localparam int HALF = 8;
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
		o_res_valid = 1'b0;
		o_res_ack = 1'b0;
		o_res_val = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick
	// Hand one byte result to the bench
	task automatic report(input logic k, input logic [7:0] v);
		o_res_ack <= k;
		o_res_val <= v;
		o_res_valid <= 1'b1;
		tick(1);
		o_res_valid <= 1'b0;
	endtask : report
	// drive low or release only, pull-up gives high
	task automatic start_cond;
		o_sda <= 1'b1;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		o_sda <= 1'b0;
		tick(HALF);
		o_scl <= 1'b0;
		tick(1);
	endtask : start_cond
	task automatic stop_cond;
		o_sda <= 1'b0;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		o_sda <= 1'b1;
		tick(HALF);
	endtask : stop_cond
	// Data set while clock low, sampled mid high phase
	task automatic bit_xfer(input logic b, output logic r);
		o_sda <= b;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF / 2);
		r = i_sda;
		tick(HALF / 2);
		o_scl <= 1'b0;
		tick(1);
	endtask : bit_xfer
	task automatic write_byte(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
		bit_xfer(1'b1, r);
		report(1'b1, {7'h00, ~r});
	endtask : write_byte
	// acknowledge wanted bytes, refuse the last
	task automatic read_byte(input logic last);
		logic [7:0] d;
		logic r;
		d = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			bit_xfer(1'b1, r);
			d = {d[6:0], r};
		end
		bit_xfer(last, r);
		report(1'b0, d);
	endtask : read_byte
endmodule : scsp_host_model
`default_nettype wire

/* File: test_serial_control_slave_port.sv */
// Self-checking bench of the serial control slave port
`timescale 1ns/1ps
`default_nettype none
module test_serial_control_slave_port;
	// ------------------------------------------------------------
	// Bench state and wiring
	// ------------------------------------------------------------
	logic I_CLK = 1'b0;
	// Left unknown so the first reset drive gives a falling edge at time 0
	logic I_NRST;
	logic [2:0] strap = 3'h0;
	logic link = 1'b1;
	logic m_scl, m_sda, res_valid, res_ack;
	logic [7:0] res_val;
	logic scl_out, scl_oe, sda_out, sda_oe, power_down, logic_reset;
	wire logic scl_w, sda_w;
	logic [8:0] exp_q[$];
	int miscompares = 0;
	int num_checks = 0;
	int pulses = 0;
	logic od_bad = 1'b0;
	logic [31:0] seed = 32'h0000_0026;
	// Wired-AND with pull-up, either party may pull low
	assign scl_w = m_scl & ~scl_oe;
	assign sda_w = m_sda & ~sda_oe;
	always #12.5 I_CLK = ~I_CLK;
	scsp_serial_control_slave_port dut_u (.I_CLK(I_CLK), .I_NRST(I_NRST),
		.I_SCL_IN(scl_w), .O_SCL_OUT(scl_out), .O_SCL_OE(scl_oe),
		.I_SDA_IN(sda_w), .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe),
		.I_ADDRESS_SELECT_STRAP(strap), .I_LINK_DETECTED(link),
		.O_POWER_DOWN(power_down), .O_LOGIC_RESET(logic_reset));
	scsp_host_model m_u (.i_clk(I_CLK), .i_sda(sda_w), .o_scl(m_scl),
		.o_sda(m_sda), .o_res_valid(res_valid), .o_res_ack(res_ack),
		.o_res_val(res_val));
	task automatic check_v(input string n, input logic [8:0] e,
		input logic [8:0] g);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : check_v
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Strap must be stable before reset is let go
	task automatic do_reset(input logic [2:0] s);
		I_NRST <= 1'b0;
		strap <= s;
		repeat (20) @(posedge I_CLK);
		I_NRST <= 1'b1;
		repeat (6) @(posedge I_CLK);
	endtask : do_reset
	// Pointer then n data bytes; a refused address ends at once
	task automatic wr(input logic [6:0] a, input logic [7:0] p, d0, d1,
		input int n, input logic ok);
		exp_q.push_back({1'b1, 7'h00, ok});
		m_u.start_cond();
		m_u.write_byte({a, 1'b0});
		if (ok)
		begin
			for (int i = 0; i <= n; i++)
			begin
				exp_q.push_back(9'h101);
				m_u.write_byte(i == 0 ? p : (i == 1 ? d0 : d1));
			end
		end
		m_u.stop_cond();
	endtask : wr
	// Two bytes from pointer zero after a repeated start
	task automatic rd(input logic [6:0] a, input logic [7:0] e0, e1);
		repeat (3) exp_q.push_back(9'h101);
		exp_q.push_back({1'b0, e0});
		exp_q.push_back({1'b0, e1});
		m_u.start_cond();
		m_u.write_byte({a, 1'b0});
		m_u.write_byte(8'h00);
		m_u.start_cond();
		m_u.write_byte({a, 1'b1});
		m_u.read_byte(1'b0);
		m_u.read_byte(1'b1);
		m_u.stop_cond();
	endtask : rd
	// Link change needs three clocks to reach the output
	task automatic pd_check(input logic l, input logic e);
		link <= l;
		repeat (6) @(posedge I_CLK);
		check_v("power_down", {8'h00, e}, {8'h00, power_down});
	endtask : pd_check
	// Reset pulses and lines that must never be driven high
	always @(posedge I_CLK)
	begin
		if (logic_reset === 1'b1) pulses++;
		if (scl_oe !== 1'b0 || sda_out !== 1'b0 || scl_out !== 1'b0)
			od_bad <= 1'b1;
	end
	// Oldest note against each byte result
	always @(posedge I_CLK)
	begin
		if (res_valid === 1'b1)
			check_v("byte_result", exp_q.size() > 0 ? exp_q.pop_front()
				: 9'h1FF, {res_ack, res_val});
	end
	// Watchdog, a hang counts as a mismatch
	initial
	begin
		repeat (100000) @(posedge I_CLK);
		miscompares++;
		finish_test();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [6:0] a, na;
		logic [31:0] r;
		for (int i = 0; i < 8; i++)
		begin
			do_reset(i[2:0]);
			a = 7'h0C + 7'(2 * i);
			wr(a, 8'h00, 8'h00, 8'h00, 0, 1'b1);
			wr(i == 7 ? 7'h0C : a + 7'h02, 8'h00, 8'h00, 8'h00, 0, 1'b0);
		end
		r = rnd();
		na = {2'b01, r[4:0]};
		wr(a, 8'h00, {na, 1'b1}, 8'h80, 2, 1'b1);
		wr(a, 8'h00, 8'h00, 8'h00, 0, 1'b0);
		rd(na, {na, 1'b1}, 8'h80);
		pd_check(1'b0, 1'b1);
		pd_check(1'b1, 1'b0);
		wr(na, 8'h01, 8'hFD, 8'h00, 1, 1'b1);
		check_v("reset_pulses", 9'h001, pulses[8:0]);
		rd(na, {na, 1'b1}, 8'h80);
		wr(na, 8'h01, 8'h82, 8'h00, 1, 1'b1);
		check_v("reset_pulses", 9'h002, pulses[8:0]);
		rd(a, 8'h00, 8'h00);
		pd_check(1'b0, 1'b0);
		check_v("open_drain", 9'h000, {8'h00, od_bad});
		check_v("pending", 9'h000, 9'(exp_q.size()));
		finish_test();
	end
endmodule : test_serial_control_slave_port
`default_nettype wire
